// ---- core/clock_divider_power_monitor.sv ----
// cpu clock prescaler, brownout/power-on monitor, idle and power-down
// assumes hclk is the oscillator clock and detector pins are async
//
// Notes on behaviour
// - half-rate config bit halves cpu clock: 12 instead of 6 clocks
// - peripheral timing tick is slowed by the same division
// - divisor zero gives undivided clock, or half with half-rate
// - divisor N of 1..255 divides the clock by 2*(N+1)
// - divisor may be rewritten anytime without stopping execution
// - brownout resets the cpu, or interrupts when select bit set
// - level bit 1 picks 2.5 V detector, 0 picks 3.8 V
// - brownout reset holds while the detector stays active
// - brownout interrupt fires once on inactive-to-active edge
// - brownout interrupt needs global and brownout enables set
// - a brownout sets the brownout flag, unless the disable bit is set, until software clears
// - disable bit suppresses brownout resets and interrupts
// - power-up detection sets power-on flag until software clears
// - idle stops cpu, peripherals run; interrupt or reset ends it
// - power-down stops oscillator, cpu and dependent peripherals
// - power-down ends on reset or higher-priority enabled irq
// - brownout wakes from power-down, or resets in reset mode
// - wakeup restarts oscillator, waits 1024 or 256 clocks
// - watchdog reset still acts during power-down
// - brownout and other analog parts keep running in power-down
// - power-down bit clears itself when power-down ends
// - idle bit clears itself when idle ends
`timescale 1ns/1ns
`include "clkpwr_defs.svh"

module clock_divider_power_monitor
    import clkpwr_pkg::*;
#(
    parameter int DIV_WIDTH = 8
) (
    input wire logic hclk,
    input wire logic hresetn,
    // ahb-lite slave
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    // factory configuration bits, async straps
    input wire logic cpu_half_rate_cfg,
    input wire logic brownout_level_select,
    input wire logic osc_is_crystal,
    // analog detectors and watchdog, async
    input wire logic brownout_below_low,
    input wire logic brownout_below_high,
    input wire logic power_on_detect,
    input wire logic watchdog_overflow,
    // interrupt controller, same clock
    input wire logic global_irq_enable,
    input wire logic brownout_irq_enable,
    input wire logic brownout_irq_ack,
    input wire logic enabled_irq_pending,
    input wire logic irq_above_in_service,
    // outputs to cpu, peripherals and oscillator
    output logic cpu_tick,
    output logic periph_tick,
    output logic cpu_reset,
    output logic brownout_irq,
    output logic osc_enable
);

    // ======================================================
    // synchronisers for everything from outside the clock
    logic [6:0] sync_a;
    logic [6:0] sync_b;
    config_bits_t cfg;
    logic bo_low_s;
    logic bo_high_s;
    logic por_s;
    logic wdt_s;

    // two flops per input; only stage b is read
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            sync_a <= 7'h00;
            sync_b <= 7'h00;
        end else begin
            sync_a <= {cpu_half_rate_cfg, brownout_level_select,
                       osc_is_crystal, brownout_below_low,
                       brownout_below_high, power_on_detect,
                       watchdog_overflow};
            sync_b <= sync_a;
        end
    end

    assign cfg = config_bits_t'(sync_b[6:4]);
    assign bo_low_s = sync_b[3];
    assign bo_high_s = sync_b[2];
    assign por_s = sync_b[1];
    assign wdt_s = sync_b[0];

    // ======================================================
    // registers
    logic [DIV_WIDTH-1:0] cpu_clock_divisor;
    logic brownout_flag;
    logic power_on_flag;
    logic [1:0] gen_flags;
    logic powerdown_request;
    logic idle_request;
    logic brownout_disable;
    logic brownout_irq_select;
    power_mode_t mode;
    bus_phase_t phase;
    logic wr_en;

    // ======================================================
    // clock prescaler
    // period in hclk cycles for a divisor and the half-rate bit
    function automatic logic [10:0] period_of(
        input logic [DIV_WIDTH-1:0] n,
        input logic half
    );
        logic [10:0] base;
        base = (n == '0) ? 11'd1 : 11'({n, 1'b0} + 11'd2);
        return half ? 11'(base << 1) : base;
    endfunction

    logic [10:0] active_period;
    logic [10:0] div_count;
    logic tick;

    // divisor is latched only at a boundary, so no short pulse
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            div_count <= 11'd0;
            active_period <= 11'd1;
        end else if (div_count + 11'd1 >= active_period) begin
            div_count <= 11'd0;
            active_period <= period_of(cpu_clock_divisor,
                                       cfg.cpu_half_rate_cfg);
        end else begin
            div_count <= div_count + 11'd1;
        end
    end

    assign tick = (div_count + 11'd1 >= active_period);

    // ticks gated by mode; peripherals share the divided rate
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            cpu_tick <= 1'b0;
            periph_tick <= 1'b0;
        end else begin
            cpu_tick <= tick && (mode == mode_run);
            periph_tick <= tick && (mode == mode_run ||
                                    mode == mode_idle);
        end
    end

    // ======================================================
    // brownout and power-on detection, never gated by mode
    logic bo_active;
    logic bo_active_q;
    logic bo_rise;
    logic bo_reset;
    logic bo_irq_pending;
    logic por_q;
    logic por_rise;

    // level 1 selects the lower detector
    assign bo_active = (cfg.brownout_level_select ? bo_low_s : bo_high_s)
                       && !brownout_disable;
    assign bo_rise = bo_active && !bo_active_q;
    assign bo_reset = bo_active && !brownout_irq_select;
    assign por_rise = por_s && !por_q;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            bo_active_q <= 1'b0;
            por_q <= 1'b0;
        end else begin
            bo_active_q <= bo_active;
            por_q <= por_s;
        end
    end

    // one event per edge; the set beats an ack in the same cycle
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            bo_irq_pending <= 1'b0;
        end else if (bo_rise && brownout_irq_select) begin
            bo_irq_pending <= 1'b1;
        end else if (brownout_irq_ack || brownout_disable) begin
            bo_irq_pending <= 1'b0;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            brownout_irq <= 1'b0;
            cpu_reset <= 1'b0;
        end else begin
            brownout_irq <= bo_irq_pending && global_irq_enable
                            && brownout_irq_enable;
            cpu_reset <= bo_reset || wdt_s;
        end
    end

    // ======================================================
    // bus slave: zero wait, always okay
    assign hreadyout = 1'b1;
    assign hresp = 1'b0;
    assign wr_en = phase.valid && phase.write;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            phase <= '0;
        end else if (hready) begin
            phase.valid <= hsel && htrans[1];
            phase.write <= hwrite;
            phase.offset <= haddr[3:0];
        end
    end

    // read data registered at the address phase
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hrdata <= 32'h0000_0000;
        end else if (hready && hsel && htrans[1] && !hwrite) begin
            unique case (haddr[3:0])
                `OFS_DIVISOR:
                    hrdata <= 32'(cpu_clock_divisor);
                `OFS_POWER_CONTROL:
                    hrdata <= {26'h0, brownout_flag, power_on_flag,
                               gen_flags, powerdown_request,
                               idle_request};
                `OFS_AUX_CONTROL:
                    hrdata <= {25'h0, brownout_disable,
                               brownout_irq_select, 5'h00};
                `OFS_STATUS:
                    hrdata <= {24'h0, bo_irq_pending, bo_active,
                               cpu_reset, osc_enable, cfg,
                               1'b0} | 32'(mode) << 8;
                default:
                    hrdata <= 32'h0000_0000;
            endcase
        end
    end

    // ======================================================
    // software registers
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            cpu_clock_divisor <= `DIVISOR_RESET;
            gen_flags <= 2'h0;
            brownout_disable <= 1'b0;
            brownout_irq_select <= 1'b0;
        end else if (wr_en) begin
            if (phase.offset == `OFS_DIVISOR) begin
                cpu_clock_divisor <= hwdata[DIV_WIDTH-1:0];
            end
            if (phase.offset == `OFS_POWER_CONTROL) begin
                gen_flags <= hwdata[`PC_GEN_FLAG_HI:`PC_GEN_FLAG_LO];
            end
            if (phase.offset == `OFS_AUX_CONTROL) begin
                brownout_disable <= hwdata[`AUX_BROWNOUT_DISABLE];
                brownout_irq_select <= hwdata[`AUX_BROWNOUT_IRQ_SEL];
            end
        end
    end

    // sticky cause flags: write 0 clears, hardware set wins
    logic pc_write;
    assign pc_write = wr_en && phase.offset == `OFS_POWER_CONTROL;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            brownout_flag <= 1'b0;
            power_on_flag <= 1'b0;
        end else begin
            if (bo_rise) begin
                brownout_flag <= 1'b1;
            end else if (pc_write && !hwdata[`PC_BROWNOUT_FLAG]) begin
                brownout_flag <= 1'b0;
            end
            if (por_rise) begin
                power_on_flag <= 1'b1;
            end else if (pc_write && !hwdata[`PC_POWER_ON_FLAG]) begin
                power_on_flag <= 1'b0;
            end
        end
    end

    // ======================================================
    // power mode sequencing
    logic [10:0] settle_count;
    logic wake_pd;
    logic leave;

    // brownout in irq mode wakes only when it is enabled
    assign wake_pd = (enabled_irq_pending && irq_above_in_service)
                     || (bo_irq_pending && global_irq_enable
                         && brownout_irq_enable);
    assign leave = (mode == mode_settle && settle_count == 11'd1);

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            mode <= mode_run;
            settle_count <= 11'd0;
        end else begin
            unique case (mode)
                mode_run: begin
                    if (powerdown_request) begin
                        mode <= mode_powerdown;
                    end else if (idle_request) begin
                        mode <= mode_idle;
                    end
                end
                mode_idle: begin
                    if (enabled_irq_pending || cpu_reset) begin
                        mode <= mode_run;
                    end
                end
                mode_powerdown: begin
                    if (wake_pd || cpu_reset) begin
                        mode <= mode_settle;
                        settle_count <= cfg.osc_is_crystal ?
                            `SETTLE_CRYSTAL : `SETTLE_RC;
                    end
                end
                mode_settle: begin
                    settle_count <= settle_count - 11'd1;
                    if (leave) begin
                        mode <= mode_run;
                    end
                end
            endcase
        end
    end

    // oscillator restarts the cycle after a wake
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            osc_enable <= 1'b1;
        end else begin
            osc_enable <= !(mode == mode_powerdown && !wake_pd
                            && !cpu_reset);
        end
    end

    // request bits: software sets, mode exit clears
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            powerdown_request <= 1'b0;
            idle_request <= 1'b0;
        end else begin
            if (leave || (mode == mode_run && cpu_reset)) begin
                powerdown_request <= 1'b0;
            end else if (pc_write && hwdata[`PC_POWERDOWN]) begin
                powerdown_request <= 1'b1;
            end
            if (mode == mode_idle
                && (enabled_irq_pending || cpu_reset)) begin
                idle_request <= 1'b0;
            end else if (pc_write && hwdata[`PC_IDLE]) begin
                idle_request <= 1'b1;
            end
        end
    end

endmodule // clock_divider_power_monitor

// ---- core/clkpwr_defs.svh ----
// register offsets, field positions, reset values and timing counts
// assumes a 32-bit word-aligned register window on the bus
`ifndef CLKPWR_DEFS_SVH
`define CLKPWR_DEFS_SVH
// ==========================================================
// register byte offsets
`define OFS_DIVISOR 4'h0
`define OFS_POWER_CONTROL 4'h4
`define OFS_AUX_CONTROL 4'h8
`define OFS_STATUS 4'hC
// ==========================================================
// power control fields
`define PC_BROWNOUT_FLAG 5
`define PC_POWER_ON_FLAG 4
`define PC_GEN_FLAG_HI 3
`define PC_GEN_FLAG_LO 2
`define PC_POWERDOWN 1
`define PC_IDLE 0
// aux control fields
`define AUX_BROWNOUT_DISABLE 6
`define AUX_BROWNOUT_IRQ_SEL 5
// ==========================================================
// reset values
`define DIVISOR_RESET 8'h00
// ==========================================================
// timing: machine cycle length and oscillator settle counts
`define CLOCKS_PER_CYCLE 6
`define CLOCKS_PER_CYCLE_HALF 12
`define SETTLE_CRYSTAL 11'd1024
`define SETTLE_RC 11'd256
`endif

// ---- core/clkpwr_pkg.sv ----
// types shared by the clock and power block
// assumes clkpwr_defs.svh holds the numbers
package clkpwr_pkg;
    // ======================================================
    // power mode of the processor
    typedef enum logic [1:0] {
        mode_run,
        mode_idle,
        mode_powerdown,
        mode_settle
    } power_mode_t;
    // ======================================================
    // captured bus address phase
    typedef struct packed {
        logic valid;
        logic write;
        logic [3:0] offset;
    } bus_phase_t;
    // factory configuration bits, after synchronising
    typedef struct packed {
        logic cpu_half_rate_cfg;
        logic brownout_level_select;
        logic osc_is_crystal;
    } config_bits_t;
endpackage

// ---- sim/clkpwr_monitor.sv ----
// checker for the clock and power block, watching its ports only
// assumes one clock domain, hresetn async active low
`timescale 1ns/1ns
module clkpwr_monitor (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hreadyout,
    input wire logic hresp,
    input wire logic brownout_below_low,
    input wire logic brownout_below_high,
    input wire logic watchdog_overflow,
    input wire logic global_irq_enable,
    input wire logic brownout_irq_enable,
    input wire logic brownout_irq_ack,
    input wire logic enabled_irq_pending,
    input wire logic irq_above_in_service,
    input wire logic cpu_tick,
    input wire logic periph_tick,
    input wire logic cpu_reset,
    input wire logic brownout_irq,
    input wire logic osc_enable
);
    default clocking @(posedge hclk); endclocking
    default disable iff (!hresetn);
    logic [10:0] since_osc;
    // ======================================================
    // cycles since the oscillator restarted, saturating
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            since_osc <= 11'h7FF;
        end else if ($rose(osc_enable)) begin
            since_osc <= 11'h000;
        end else if (since_osc != 11'h7FF) begin
            since_osc <= since_osc + 11'h001;
        end
    end
    // ======================================================
    // wake requests seen while the oscillator is stopped
    sequence s_wake_req;
        !osc_enable && enabled_irq_pending && irq_above_in_service;
    endsequence
    sequence s_quiet;
        !(brownout_below_low || brownout_below_high ||
          watchdog_overflow) [*8];
    endsequence
    a_bus_okay: assert property (hreadyout && !hresp)
        else $error("bus answer not ready or not okay");
    a_tick_pair: assert property (cpu_tick |-> periph_tick)
        else $error("cpu tick without peripheral tick");
    a_osc_off_ticks: assert property (!osc_enable [*2] |->
        !cpu_tick && !periph_tick)
        else $error("tick while oscillator stopped");
    a_irq_needs_en: assert property (brownout_irq |->
        $past(global_irq_enable && brownout_irq_enable))
        else $error("brownout irq without both enables");
    a_ack_clear: assert property (brownout_irq_ack |->
        ##[2:3] !brownout_irq)
        else $error("brownout irq stays after ack");
    a_reset_quiet: assert property (s_quiet |=> !cpu_reset)
        else $error("cpu reset with detectors quiet");
    a_settle_wait: assert property (cpu_tick |->
        since_osc >= 11'h100)
        else $error("cpu tick before oscillator settled");
    a_pd_irq_wake: assert property (s_wake_req |->
        ##[1:3] osc_enable)
        else $error("no wake on enabled higher irq");
    a_bo_wake: assert property (brownout_irq |-> osc_enable)
        else $error("no wake on brownout irq");
    a_reset_wake: assert property ($rose(cpu_reset) &&
        !osc_enable |-> ##[0:2] osc_enable)
        else $error("no wake on reset in power-down");
endmodule // clkpwr_monitor

bind clock_divider_power_monitor clkpwr_monitor mon (
    .hclk(hclk), .hresetn(hresetn), .hreadyout(hreadyout),
    .hresp(hresp), .brownout_below_low(brownout_below_low),
    .brownout_below_high(brownout_below_high),
    .watchdog_overflow(watchdog_overflow),
    .global_irq_enable(global_irq_enable),
    .brownout_irq_enable(brownout_irq_enable),
    .brownout_irq_ack(brownout_irq_ack),
    .enabled_irq_pending(enabled_irq_pending),
    .irq_above_in_service(irq_above_in_service), .cpu_tick(cpu_tick),
    .periph_tick(periph_tick), .cpu_reset(cpu_reset),
    .brownout_irq(brownout_irq), .osc_enable(osc_enable));

// ---- sim/irq_ctl_model.sv ----
// interrupt controller model acknowledging brownout requests
// assumes the block's clock; ack delay chosen by the bench
`timescale 1ns/1ns
module irq_ctl_model (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic brownout_irq,
    input wire logic [3:0] ack_delay,
    output logic brownout_irq_ack
);
    logic [3:0] wait_cnt;
    // ======================================================
    // vector after a delay, then acknowledge with one pulse
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wait_cnt <= 4'h0;
            brownout_irq_ack <= 1'b0;
        end else if (brownout_irq && !brownout_irq_ack &&
                     wait_cnt >= ack_delay) begin
            wait_cnt <= 4'h0;
            brownout_irq_ack <= 1'b1;
        end else begin
            wait_cnt <= brownout_irq ? wait_cnt + 4'h1 : 4'h0;
            brownout_irq_ack <= 1'b0;
        end
    end
endmodule // irq_ctl_model

// ---- sim/tb_top.sv ----
// self-checking bench for the clock and power block
// assumes the interrupt controller model and the bound checker
`timescale 1ns/1ns
`include "clkpwr_defs.svh"
module tb_top;
    logic hclk, hresetn, hsel, hwrite, hready, hreadyout, hresp;
    logic [31:0] haddr, hwdata, hrdata;
    logic [1:0] htrans;
    logic [2:0] hsize;
    logic half, level, xtal, bo_lo, bo_hi, pon, wdog;
    logic g_en, b_en, ack, pend, above;
    logic cpu_tick, periph_tick, cpu_reset, brownout_irq, osc_enable;
    logic [3:0] ack_delay;
    int bad_count, check_count, cycles;
    assign hready = hreadyout;
    clock_divider_power_monitor dut (.hclk(hclk), .hresetn(hresetn),
        .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
        .hsize(hsize), .hwdata(hwdata), .hready(hready),
        .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
        .cpu_half_rate_cfg(half), .brownout_level_select(level),
        .osc_is_crystal(xtal), .brownout_below_low(bo_lo),
        .brownout_below_high(bo_hi), .power_on_detect(pon),
        .watchdog_overflow(wdog), .global_irq_enable(g_en),
        .brownout_irq_enable(b_en), .brownout_irq_ack(ack),
        .enabled_irq_pending(pend), .irq_above_in_service(above),
        .cpu_tick(cpu_tick), .periph_tick(periph_tick),
        .cpu_reset(cpu_reset), .brownout_irq(brownout_irq),
        .osc_enable(osc_enable));
    irq_ctl_model partner (.hclk(hclk), .hresetn(hresetn),
        .brownout_irq(brownout_irq), .ack_delay(ack_delay),
        .brownout_irq_ack(ack));
    // ======================================================
    // clock and hang guard
    initial begin
        hclk = 1'b0;
        forever #2 hclk = ~hclk;
    end
    always @(posedge hclk) begin
        cycles++;
        if (cycles == 80000) begin
            $display("[FAIL] timeout");
            bad_count++;
            finish_test();
        end
    end
    // ======================================================
    // helpers
    task chk(input string name, input logic [31:0] seen,
             input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            bad_count++;
            $display("[FAIL] %s exp %h seen %h", name, exp, seen);
        end
    endtask
    task cyc(input int n);
        repeat (n) @(posedge hclk);
    endtask
    // single word transfer; entered just after a rising edge
    task xfer(input logic wr, input logic [31:0] a,
              input logic [31:0] d, output logic [31:0] q);
        hsel <= 1'b1;
        haddr <= a;
        htrans <= 2'b10;
        hwrite <= wr;
        hsize <= 3'b010;
        do @(posedge hclk); while (hready !== 1'b1);
        htrans <= 2'b00;
        hsel <= 1'b0;
        hwdata <= d;
        do @(posedge hclk); while (hready !== 1'b1);
        q = hrdata;
    endtask
    task wr(input logic [31:0] a, input logic [31:0] d);
        logic [31:0] q;
        xfer(1'b1, a, d, q);
    endtask
    task period(output int p);
        p = 0;
        @(posedge hclk iff cpu_tick === 1'b1);
        do begin
            @(posedge hclk);
            p++;
        end while (cpu_tick !== 1'b1);
    endtask
    task count_ticks(input int n, output int c, output int pc);
        c = 0;
        pc = 0;
        repeat (n) begin
            @(posedge hclk);
            c += $isunknown(cpu_tick) ? 99 : int'(cpu_tick);
            pc += $isunknown(periph_tick) ? 99 : int'(periph_tick);
        end
    endtask
    function automatic int exp_period(input logic [7:0] n, input int h);
        int p;
        p = (n == 8'h00) ? 1 : 2 * (int'(n) + 1);
        return (h != 0) ? 2 * p : p;
    endfunction
    task finish_test();
        $display("checks %0d mismatches %0d", check_count, bad_count);
        if (bad_count == 0 && check_count > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask
    // ======================================================
    // main sequence
    initial begin
        int p, old, c, pc, st;
        logic [31:0] q;
        logic [7:0] nv [4];
        {hresetn, hsel, hwrite, half, xtal, bo_lo, bo_hi, pon} = 8'h00;
        {wdog, g_en, b_en, pend, above, level} = 6'h01;
        {haddr, hwdata, htrans, hsize, ack_delay} = 73'h0;
        void'($urandom(32'h0ABE9C78));
        cyc(10);
        hresetn <= 1'b1;
        ack_delay <= 4'($urandom_range(0, 7));
        xfer(1'b0, `OFS_DIVISOR, 32'h0, q);
        chk("divisor_reset", q, 32'h0);
        xfer(1'b0, `OFS_STATUS, 32'h0, q);
        chk("status_reset", q, 32'h0000_0014);
        nv = '{8'h00, 8'h01, 8'hFF, 8'($urandom_range(2, 254))};
        for (int h = 0; h < 2; h++) begin
            half <= h[0];
            cyc(4);
            period(p);
            period(old);
            for (int i = 0; i < 4; i++) begin
                wr(`OFS_DIVISOR, {24'h0, nv[i]});
                period(p);
                chk("switch",
                    p == old || p == exp_period(nv[i], h), 1);
                period(p);
                chk("period", p, exp_period(nv[i], h));
                old = p;
            end
        end
        half <= 1'b0;
        wr(`OFS_DIVISOR, 32'h0);
        wr(`OFS_AUX_CONTROL, 32'h20);
        bo_lo <= 1'b1;
        cyc(10);
        chk("irq_masked", brownout_irq, 1'b0);
        chk("irq_mode_reset", cpu_reset, 1'b0);
        g_en <= 1'b1;
        b_en <= 1'b1;
        @(posedge hclk iff brownout_irq === 1'b1);
        cyc(30);
        chk("irq_once", brownout_irq, 1'b0);
        xfer(1'b0, `OFS_POWER_CONTROL, 32'h0, q);
        chk("bo_flag", q[5], 1'b1);
        bo_lo <= 1'b0;
        cyc(6);
        wr(`OFS_POWER_CONTROL, 32'h0);
        xfer(1'b0, `OFS_POWER_CONTROL, 32'h0, q);
        chk("bo_flag_clear", q[5], 1'b0);
        wr(`OFS_POWER_CONTROL, 32'h2);
        cyc(6);
        chk("pd_osc", osc_enable, 1'b0);
        bo_lo <= 1'b1;
        cyc(8);
        chk("bo_wake", osc_enable, 1'b1);
        bo_lo <= 1'b0;
        @(posedge hclk iff cpu_tick === 1'b1);
        wr(`OFS_AUX_CONTROL, 32'h0);
        {level, g_en, b_en} <= 3'h0;
        bo_lo <= 1'b1;
        cyc(8);
        chk("level_low_off", cpu_reset, 1'b0);
        bo_hi <= 1'b1;
        cyc(8);
        chk("bo_reset", cpu_reset, 1'b1);
        cyc(40);
        chk("bo_reset_held", cpu_reset, 1'b1);
        {bo_hi, bo_lo} <= 2'h0;
        cyc(8);
        chk("bo_reset_end", cpu_reset, 1'b0);
        wr(`OFS_AUX_CONTROL, 32'h40);
        bo_hi <= 1'b1;
        cyc(8);
        chk("bo_disabled", cpu_reset, 1'b0);
        bo_hi <= 1'b0;
        level <= 1'b1;
        pon <= 1'b1;
        cyc(6);
        pon <= 1'b0;
        xfer(1'b0, `OFS_POWER_CONTROL, 32'h0, q);
        chk("pon_flag", q[4], 1'b1);
        wr(`OFS_POWER_CONTROL, 32'h0);
        xfer(1'b0, `OFS_POWER_CONTROL, 32'h0, q);
        chk("pon_clear", q[4], 1'b0);
        wr(`OFS_POWER_CONTROL, 32'h1);
        cyc(4);
        count_ticks(20, c, pc);
        chk("idle_cpu", c, 0);
        chk("idle_periph", pc, 20);
        pend <= 1'b1;
        cyc(1);
        pend <= 1'b0;
        cyc(4);
        xfer(1'b0, `OFS_POWER_CONTROL, 32'h0, q);
        chk("idle_bit", q[0], 1'b0);
        count_ticks(8, c, pc);
        chk("idle_exit", c, 8);
        for (int x = 0; x < 2; x++) begin
            xtal <= x[0];
            st = (x == 1) ? 1024 : 256;
            cyc(4);
            wr(`OFS_POWER_CONTROL, 32'h2);
            cyc(6);
            count_ticks(10, c, pc);
            chk("pd_ticks", c + pc, 0);
            pend <= 1'b1;
            cyc(10);
            chk("pd_low_prio", osc_enable, 1'b0);
            above <= 1'b1;
            @(posedge hclk iff osc_enable === 1'b1);
            {pend, above} <= 2'h0;
            p = 0;
            while (cpu_tick !== 1'b1) begin
                @(posedge hclk);
                p++;
            end
            chk("settle", p >= st && p <= st + 4, 1);
            xfer(1'b0, `OFS_POWER_CONTROL, 32'h0, q);
            chk("pd_bit", q[1], 1'b0);
        end
        wr(`OFS_POWER_CONTROL, 32'h2);
        cyc(6);
        wdog <= 1'b1;
        cyc(6);
        chk("wdog_pd", cpu_reset, 1'b1);
        wdog <= 1'b0;
        @(posedge hclk iff cpu_tick === 1'b1);
        finish_test();
    end
endmodule // tb_top
